// ==== fie_pkg.sv ====
// How it works
// (R01) Fast undervoltage enable bits 5:0 gate each channel's fault onto the alert.
// (R02) Slow undervoltage enable bits 5:0 allow or block each channel's fault.
// (R03) Fast overvoltage enable bits 5:0 allow or block each channel's fault.
// (R04) Slow overvoltage enable bits 5:0 allow or block each channel's fault.
// (R05) Power-up sequence enables gate faults of the sequence after request rises.
// (R06) Power-down sequence enables gate faults of the sequence after request falls.
// (R07) Wake sequence enables gate faults of the sequence after sleep rises.
// (R08) Doze sequence enables gate faults of the sequence after sleep falls.
// (R09) Alert follows enabled faults; the force bit drives it low regardless.
// (R10) Alert low while any latched fault is enabled; bits 7:6 never matter.
package fie_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] UV_FAST_IRQ_ENABLE_ADDR = 8'h13;
    localparam logic [7:0] UV_SLOW_IRQ_ENABLE_ADDR = 8'h14;
    localparam logic [7:0] OV_FAST_IRQ_ENABLE_ADDR = 8'h15;
    localparam logic [7:0] OV_SLOW_IRQ_ENABLE_ADDR = 8'h16;
    localparam logic [7:0] POWER_UP_SEQ_IRQ_ENABLE_ADDR = 8'h17;
    localparam logic [7:0] POWER_DOWN_SEQ_IRQ_ENABLE_ADDR = 8'h18;
    localparam logic [7:0] WAKE_SEQ_IRQ_ENABLE_ADDR = 8'h19;
    localparam logic [7:0] DOZE_SEQ_IRQ_ENABLE_ADDR = 8'h1a;
    // Bank layout
    localparam int BANK_BASE = 8'h13;
    localparam int BANK_COUNT = 8;
    localparam int CHANNEL_COUNT = 6;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] RESERVED_MASK = 8'hc0;
    // Fault class index within the bank
    typedef enum logic [2:0] {
        CLASS_UV_FAST,
        CLASS_UV_SLOW,
        CLASS_OV_FAST,
        CLASS_OV_SLOW,
        CLASS_POWER_UP,
        CLASS_POWER_DOWN,
        CLASS_WAKE,
        CLASS_DOZE
    } fie_class_type;
endpackage

// ==== fie_bank.sv ====
`timescale 1ns/1ps
module fie_bank #(
    parameter int CHANNELS = fie_pkg::CHANNEL_COUNT
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    input wire logic alert_force_bit,
    input wire logic [fie_pkg::BANK_COUNT*6-1:0] fault_latched,
    output logic fault_alert_low_out,
    output logic fault_alert_low_oe
);
    import fie_pkg::*;

    // Field slicing below is laid out for six channels per class only
    if (CHANNELS != CHANNEL_COUNT) begin : gen_channel_check
        $error("fie_bank serves six channels only");
    end

    // ------------------------------------------------------------
    // Enable registers
    // ------------------------------------------------------------
    logic [7:0] enable_reg [BANK_COUNT];
    logic [BANK_COUNT-1:0] gated_class;
    logic [7:0] offset;
    logic in_bank;
    logic [BANK_COUNT*8-1:0] enable_flat;

    assign offset = reg_addr - 8'(BANK_BASE);
    assign in_bank = (reg_addr >= UV_FAST_IRQ_ENABLE_ADDR) && (reg_addr <= DOZE_SEQ_IRQ_ENABLE_ADDR);

    // One register per class; all bits R/W, 7:6 stored but unused
    genvar g;
    generate
        for (g = 0; g < BANK_COUNT; g++) begin : gen_class
            always_ff @(posedge ref_clk) begin
                if (!reset_n) begin
                    enable_reg[g] <= ENABLE_RESET;
                end else if (reg_write && in_bank && offset == 8'(g)) begin
                    enable_reg[g] <= reg_wdata;
                end
            end
            // Only bits 5:0 reach the alert, reserved bits are masked R10
            assign gated_class[g] = |(enable_reg[g][5:0] & fault_latched[g*6 +: 6]);
            // Flat view for whole-bank checks
            assign enable_flat[g*8 +: 8] = enable_reg[g];
        end
    endgenerate

    // Readback registered so data comes from flops
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
            reg_hit <= 1'b0;
        end else begin
            reg_hit <= in_bank;
            reg_rdata <= in_bank ? enable_reg[offset[2:0]] : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Alert output
    // ------------------------------------------------------------
    // Registered to avoid glitches on the open-drain line
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            fault_alert_low_oe <= 1'b1;
        end else begin
            // R01 R02 R03 R04 R05 R06 R07 R08 R10
            // Force overrides faults and enables R09
            fault_alert_low_oe <= !(alert_force_bit || |gated_class);
        end
    end
    // Open drain: only ever pulls low
    assign fault_alert_low_out = 1'b0;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    uv_fast_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R01
        (|(enable_reg[0][5:0] & fault_latched[5:0])) |=> !fault_alert_low_oe)
        else $error("fast undervoltage fault not signalled");
    uv_slow_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R02
        (|(enable_reg[1][5:0] & fault_latched[11:6])) |=> !fault_alert_low_oe)
        else $error("slow undervoltage fault not signalled");
    ov_fast_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R03
        (|(enable_reg[2][5:0] & fault_latched[17:12])) |=> !fault_alert_low_oe)
        else $error("fast overvoltage fault not signalled");
    ov_slow_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R04
        (|(enable_reg[3][5:0] & fault_latched[23:18])) |=> !fault_alert_low_oe)
        else $error("slow overvoltage fault not signalled");
    power_up_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R05
        (|(enable_reg[4][5:0] & fault_latched[29:24])) |=> !fault_alert_low_oe)
        else $error("power-up sequence fault not signalled");
    power_down_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R06
        (|(enable_reg[5][5:0] & fault_latched[35:30])) |=> !fault_alert_low_oe)
        else $error("power-down sequence fault not signalled");
    wake_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R07
        (|(enable_reg[6][5:0] & fault_latched[41:36])) |=> !fault_alert_low_oe)
        else $error("wake sequence fault not signalled");
    doze_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R08
        (|(enable_reg[7][5:0] & fault_latched[47:42])) |=> !fault_alert_low_oe)
        else $error("doze sequence fault not signalled");
    force_alert_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R09
        alert_force_bit |=> !fault_alert_low_oe)
        else $error("force bit did not pull alert low");
    quiet_alert_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R10
        (!alert_force_bit && !(|gated_class)) |=> fault_alert_low_oe)
        else $error("alert low with no enabled fault");
    write_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (reg_write && in_bank) ##1 !reg_write && reg_addr == $past(reg_addr)
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("enable register readback wrong");

    // ------------------------------------------------------------
    // Register storage checks
    // ------------------------------------------------------------
    // A write to one address lands in that register, all 8 bits

    // Fast undervoltage enables
    uv_fast_store_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R01
        (reg_write && reg_addr == UV_FAST_IRQ_ENABLE_ADDR)
        |=> enable_reg[0] == $past(reg_wdata))
        else $error("fast undervoltage enable write lost");

    // Slow undervoltage enables
    uv_slow_store_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R02
        (reg_write && reg_addr == UV_SLOW_IRQ_ENABLE_ADDR)
        |=> enable_reg[1] == $past(reg_wdata))
        else $error("slow undervoltage enable write lost");

    // Fast overvoltage enables
    ov_fast_store_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R03
        (reg_write && reg_addr == OV_FAST_IRQ_ENABLE_ADDR)
        |=> enable_reg[2] == $past(reg_wdata))
        else $error("fast overvoltage enable write lost");

    // Slow overvoltage enables
    ov_slow_store_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R04
        (reg_write && reg_addr == OV_SLOW_IRQ_ENABLE_ADDR)
        |=> enable_reg[3] == $past(reg_wdata))
        else $error("slow overvoltage enable write lost");

    // Power-up sequence enables
    power_up_store_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R05
        (reg_write && reg_addr == POWER_UP_SEQ_IRQ_ENABLE_ADDR)
        |=> enable_reg[4] == $past(reg_wdata))
        else $error("power-up enable write lost");

    // Power-down sequence enables
    power_down_store_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R06
        (reg_write && reg_addr == POWER_DOWN_SEQ_IRQ_ENABLE_ADDR)
        |=> enable_reg[5] == $past(reg_wdata))
        else $error("power-down enable write lost");

    // Wake sequence enables
    wake_store_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R07
        (reg_write && reg_addr == WAKE_SEQ_IRQ_ENABLE_ADDR)
        |=> enable_reg[6] == $past(reg_wdata))
        else $error("wake enable write lost");

    // Doze sequence enables
    doze_store_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R08
        (reg_write && reg_addr == DOZE_SEQ_IRQ_ENABLE_ADDR)
        |=> enable_reg[7] == $past(reg_wdata))
        else $error("doze enable write lost");

    // ------------------------------------------------------------
    // Register hold checks
    // ------------------------------------------------------------
    // No write to its own address, no change: catches aliasing in the decode

    // Fast undervoltage enables
    uv_fast_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R01
        !(reg_write && reg_addr == UV_FAST_IRQ_ENABLE_ADDR)
        |=> $stable(enable_reg[0]))
        else $error("fast undervoltage enable changed unasked");

    // Slow undervoltage enables
    uv_slow_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R02
        !(reg_write && reg_addr == UV_SLOW_IRQ_ENABLE_ADDR)
        |=> $stable(enable_reg[1]))
        else $error("slow undervoltage enable changed unasked");

    // Fast overvoltage enables
    ov_fast_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R03
        !(reg_write && reg_addr == OV_FAST_IRQ_ENABLE_ADDR)
        |=> $stable(enable_reg[2]))
        else $error("fast overvoltage enable changed unasked");

    // Slow overvoltage enables
    ov_slow_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R04
        !(reg_write && reg_addr == OV_SLOW_IRQ_ENABLE_ADDR)
        |=> $stable(enable_reg[3]))
        else $error("slow overvoltage enable changed unasked");

    // Power-up sequence enables
    power_up_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R05
        !(reg_write && reg_addr == POWER_UP_SEQ_IRQ_ENABLE_ADDR)
        |=> $stable(enable_reg[4]))
        else $error("power-up enable changed unasked");

    // Power-down sequence enables
    power_down_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R06
        !(reg_write && reg_addr == POWER_DOWN_SEQ_IRQ_ENABLE_ADDR)
        |=> $stable(enable_reg[5]))
        else $error("power-down enable changed unasked");

    // Wake sequence enables
    wake_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R07
        !(reg_write && reg_addr == WAKE_SEQ_IRQ_ENABLE_ADDR)
        |=> $stable(enable_reg[6]))
        else $error("wake enable changed unasked");

    // Doze sequence enables
    doze_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R08
        !(reg_write && reg_addr == DOZE_SEQ_IRQ_ENABLE_ADDR)
        |=> $stable(enable_reg[7]))
        else $error("doze enable changed unasked");

    // ------------------------------------------------------------
    // Readback checks
    // ------------------------------------------------------------
    // Each address returns its own register one cycle later

    // Fast undervoltage enables
    uv_fast_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R01
        (reg_addr == UV_FAST_IRQ_ENABLE_ADDR)
        |=> reg_hit && reg_rdata == $past(enable_reg[0]))
        else $error("fast undervoltage enable read wrong");

    // Slow undervoltage enables
    uv_slow_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R02
        (reg_addr == UV_SLOW_IRQ_ENABLE_ADDR)
        |=> reg_hit && reg_rdata == $past(enable_reg[1]))
        else $error("slow undervoltage enable read wrong");

    // Fast overvoltage enables
    ov_fast_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R03
        (reg_addr == OV_FAST_IRQ_ENABLE_ADDR)
        |=> reg_hit && reg_rdata == $past(enable_reg[2]))
        else $error("fast overvoltage enable read wrong");

    // Slow overvoltage enables
    ov_slow_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R04
        (reg_addr == OV_SLOW_IRQ_ENABLE_ADDR)
        |=> reg_hit && reg_rdata == $past(enable_reg[3]))
        else $error("slow overvoltage enable read wrong");

    // Power-up sequence enables
    power_up_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R05
        (reg_addr == POWER_UP_SEQ_IRQ_ENABLE_ADDR)
        |=> reg_hit && reg_rdata == $past(enable_reg[4]))
        else $error("power-up enable read wrong");

    // Power-down sequence enables
    power_down_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R06
        (reg_addr == POWER_DOWN_SEQ_IRQ_ENABLE_ADDR)
        |=> reg_hit && reg_rdata == $past(enable_reg[5]))
        else $error("power-down enable read wrong");

    // Wake sequence enables
    wake_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R07
        (reg_addr == WAKE_SEQ_IRQ_ENABLE_ADDR)
        |=> reg_hit && reg_rdata == $past(enable_reg[6]))
        else $error("wake enable read wrong");

    // Doze sequence enables
    doze_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R08
        (reg_addr == DOZE_SEQ_IRQ_ENABLE_ADDR)
        |=> reg_hit && reg_rdata == $past(enable_reg[7]))
        else $error("doze enable read wrong");

    // ------------------------------------------------------------
    // Decode, reset and alert corner checks
    // ------------------------------------------------------------
    // Writes outside the bank are dropped silently, so nothing may move

    // Stray writes
    stray_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (reg_write && !in_bank) |=> $stable(enable_flat))
        else $error("write outside bank changed an enable");

    // Reads outside the bank return zero
    miss_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !in_bank |=> !reg_hit && reg_rdata == 8'h00)
        else $error("read outside bank not zero");

    // Reset is synchronous: one edge brings back the idle state
    reset_state_a: assert property (@(posedge ref_clk)
        !reset_n |=> enable_flat == {BANK_COUNT{ENABLE_RESET}} && fault_alert_low_oe
            && !reg_hit && reg_rdata == 8'h00)
        else $error("reset state wrong");

    // Force alone, with no fault at all, still pulls the line
    force_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R09
        (alert_force_bit && !(|fault_latched)) |=> !fault_alert_low_oe)
        else $error("force without faults did not pull alert low");

    // No fault and no force means no alert, whatever the enables and bits 7:6 hold
    no_fault_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R10
        (!alert_force_bit && !(|fault_latched)) |=> fault_alert_low_oe)
        else $error("alert low without any fault");

    force_seen_c: cover property (@(posedge ref_clk) alert_force_bit ##1 !fault_alert_low_oe);
    fault_seen_c: cover property (@(posedge ref_clk) (|gated_class) ##1 !fault_alert_low_oe);
    blocked_c: cover property (@(posedge ref_clk) (|fault_latched) && !(|gated_class));
    reserved_write_c: cover property (@(posedge ref_clk)
        reg_write && in_bank && reg_wdata[7:6] != 2'b00);
    stray_write_c: cover property (@(posedge ref_clk) reg_write && !in_bank);
endmodule // fie_bank

// ==== fie_host_model.sv ====
`timescale 1ns/1ps
// Host side of the open-drain alert line, with its pull-up
module fie_host_model (
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic alert_line
);
    // Pull-up wins whenever the device releases the pin
    assign alert_line = pin_oe ? 1'b1 : pin_out;
endmodule // fie_host_model

// ==== fie_bank_tb_top.sv ====
`timescale 1ns/1ps
module fie_bank_tb_top;
    import fie_pkg::*;
    logic ref_clk, reset_n, reg_write, alert_force_bit, reg_hit, alert_line;
    logic fault_alert_low_out, fault_alert_low_oe;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [47:0] fault_latched;
    logic [7:0] mem [8];
    int bad_count = 0;
    int compares = 0;
    integer seed = 11753;
    fie_bank dut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_write(reg_write),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_hit(reg_hit), .alert_force_bit(alert_force_bit),
        .fault_latched(fault_latched), .fault_alert_low_out(fault_alert_low_out),
        .fault_alert_low_oe(fault_alert_low_oe));
    fie_host_model host (.pin_out(fault_alert_low_out), .pin_oe(fault_alert_low_oe),
        .alert_line(alert_line));
    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Only bits 5:0 gate; force overrides everything
    function logic exp_alert(input logic [47:0] f, input logic frc);
        logic a;
        a = frc;
        for (int k = 0; k < 8; k++) a |= |(f[k*6+:6] & mem[k][5:0]);
        return a;
    endfunction
    task conclude;
        $display("Mismatches %0d, comparisons %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Clock and stimulus
    // ------------------------------------------------------------
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Reset reads first, then reserved-bit writes, then random traffic
    initial begin
        logic [7:0] a, d;
        logic [47:0] f;
        logic fr, we, hit;
        reset_n = 0; reg_write = 0; reg_addr = 8'h00; reg_wdata = 8'h00;
        alert_force_bit = 0; fault_latched = '0;
        for (int k = 0; k < 8; k++) mem[k] = ENABLE_RESET;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1;
        for (int i = 0; i < 300; i++) begin
            we = i >= 8;
            a = i < 16 ? 8'h13 + 8'(i % 8) : 8'h12 + 8'($unsigned($random(seed)) % 10);
            d = i < 16 ? 8'hc0 : 8'($random(seed));
            f = i < 16 ? '1 : {16'($random(seed)), 32'($random(seed))};
            fr = i < 16 ? 1'b0 : ($unsigned($random(seed)) % 5 == 0);
            @(posedge ref_clk);
            reg_write <= we; reg_addr <= a; reg_wdata <= d;
            fault_latched <= f; alert_force_bit <= fr;
            @(posedge ref_clk);
            reg_write <= 1'b0;
            hit = a >= 8'h13 && a <= 8'h1a;
            if (we && hit) mem[a - 8'h13] = d;
            @(posedge ref_clk);
            #1;
            check("reg_rdata", reg_rdata, hit ? mem[a - 8'h13] : 8'h00);
            check("reg_hit", {7'd0, reg_hit}, {7'd0, hit});
            check("alert_oe", {7'd0, fault_alert_low_oe}, {7'd0, ~exp_alert(f, fr)});
            check("alert_line", {7'd0, alert_line}, {7'd0, ~exp_alert(f, fr)});
        end
        conclude();
    end
endmodule // fie_bank_tb_top
